/* logic/htd_debug_csrs.sv */
// Module: per-hart debug and trigger CSR set
// Function
// [RL1] Trigger CSRs debug/machine; debug CSRs debug only
// [RL2] Selection index picks the trigger data bank
// [RL3] Selection index is full-width write-any-read-legal
// [RL4] Unimplemented index writes leave a legal value
// [RL5] Software checks type code for existence
// [RL6] Trigger data registers full-width, banked by index
// [RL7] Read-only type nibble atop first data
// [RL8] Type 0 absent, 2 match, others reserved
// [RL9] Debug-view bit reserves trigger for debug
// [RL10] Machine access to debug-view trigger is illegal
// [RL11] Debug entry copies program counter to debug PC
// [RL12] Debug exit resumes at debug PC
// [RL13] Scratch reserved for debug firmware use
// [RL14] Match triggers report read-only type 2
// [RL15] Eight breakpoint triggers per hart
// [RL16] Standard CSR addresses; bad privilege is illegal
`timescale 1ns/1ps
`default_nettype none
module htd_debug_csrs #(
  parameter int NUM_TRIG = htd_pkg::NUM_TRIGGERS
) (
  input  wire logic        i_core_clk,    // Core clock, 50 MHz
  input  wire logic        i_srst,        // Synchronous reset, active high
  input  wire logic        i_csr_valid,   // CSR access request, one cycle
  input  wire logic        i_csr_write,   // 1 write, 0 read
  input  wire logic [11:0] i_csr_addr,    // CSR address
  input  wire logic [31:0] i_csr_wdata,   // Write data
  input  wire logic        i_debug_mode,  // Core is in debug mode
  input  wire logic        i_debug_enter, // Pulse: entering debug mode
  input  wire logic        i_debug_exit,  // Pulse: leaving debug mode
  input  wire logic [31:0] i_pc,          // Current program counter
  output logic             o_csr_ack,     // Access answered
  output logic [31:0]      o_csr_rdata,   // Read data
  output logic             o_csr_illegal, // Illegal instruction exception
  output logic             o_resume,      // Pulse: resume at o_resume_pc
  output logic [31:0]      o_resume_pc    // Resume address
);
  localparam int IDX_W = (NUM_TRIG > 1) ? $clog2(NUM_TRIG) : 1;

  if (NUM_TRIG < 1 || NUM_TRIG > 256) begin : g_bad_num
    $error("NUM_TRIG out of range");
  end

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  function automatic logic is_trig_data(input logic [11:0] a);
    return a == htd_pkg::CSR_TRIGGER_DATA_FIRST || a == htd_pkg::CSR_TRIGGER_DATA_SECOND ||
           a == htd_pkg::CSR_TRIGGER_DATA_THIRD;
  endfunction
  function automatic logic is_debug_only(input logic [11:0] a);
    return a == htd_pkg::CSR_DEBUG_CONTROL || a == htd_pkg::CSR_DEBUG_PC ||
           a == htd_pkg::CSR_DEBUG_SCRATCH;
  endfunction

  logic [31:0]      sel_r;
  logic [31:0]      dcsr_r;
  logic [31:0]      dpc_r;
  logic [31:0]      scratch_r;
  logic [31:0]      rd_nxt;
  logic             illegal_nxt;
  logic             ok;
  htd_pkg::htd_op_t op;

  htd_trig_if #(.IDX_W(IDX_W)) tif ();

  htd_trig_bank #(.NUM(NUM_TRIG), .IDX_W(IDX_W)) u_bank (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .t          (tif.bank)
  );

  always_comb begin
    op = htd_pkg::HTD_OP_NONE;
    if (i_csr_valid)
      op = i_csr_write ? htd_pkg::HTD_OP_WRITE : htd_pkg::HTD_OP_READ;
  end

  always_comb begin
    illegal_nxt = 1'b0;
    if (op != htd_pkg::HTD_OP_NONE) begin
      if (is_debug_only(i_csr_addr) && !i_debug_mode)                  // RL1 RL16
        illegal_nxt = 1'b1;
      else if (is_trig_data(i_csr_addr) && !i_debug_mode && tif.dmode) // RL10 RL9
        illegal_nxt = 1'b1;
      else if (!is_debug_only(i_csr_addr) && !is_trig_data(i_csr_addr) &&
               i_csr_addr != htd_pkg::CSR_TRIGGER_SELECT)              // RL16
        illegal_nxt = 1'b1;
    end
  end
  assign ok = (op == htd_pkg::HTD_OP_WRITE) && !illegal_nxt;

  assign tif.sel   = sel_r[IDX_W-1:0];                                 // RL2
  assign tif.field = 2'(i_csr_addr - htd_pkg::CSR_TRIGGER_DATA_FIRST);
  assign tif.wr    = ok && is_trig_data(i_csr_addr);
  assign tif.dbg   = i_debug_mode;
  assign tif.wdata = i_csr_wdata;

  // ------------------------------------------------------------
  // Selection index
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_srst)
      sel_r <= htd_pkg::ZERO_WORD;
    else if (ok && i_csr_addr == htd_pkg::CSR_TRIGGER_SELECT) begin
      if (i_csr_wdata < 32'(NUM_TRIG))                                 // RL3 RL4
        sel_r <= i_csr_wdata;
    end
  end

  // ------------------------------------------------------------
  // Debug control, PC and scratch
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_srst)
      dcsr_r <= htd_pkg::DEBUG_CONTROL_RST;
    else if (ok && i_csr_addr == htd_pkg::CSR_DEBUG_CONTROL)
      dcsr_r <= i_csr_wdata;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst)
      dpc_r <= htd_pkg::ZERO_WORD;
    else if (i_debug_enter)
      dpc_r <= i_pc;                                                   // RL11
    else if (ok && i_csr_addr == htd_pkg::CSR_DEBUG_PC)
      dpc_r <= i_csr_wdata;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst)
      scratch_r <= htd_pkg::ZERO_WORD;
    else if (ok && i_csr_addr == htd_pkg::CSR_DEBUG_SCRATCH)
      scratch_r <= i_csr_wdata;                                        // RL13
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_resume    <= 1'b0;
      o_resume_pc <= htd_pkg::ZERO_WORD;
    end else begin
      o_resume <= i_debug_exit;                                        // RL12
      if (i_debug_exit)
        o_resume_pc <= dpc_r;
    end
  end

  // ------------------------------------------------------------
  // Answer
  // ------------------------------------------------------------
  always_comb begin
    rd_nxt = htd_pkg::ZERO_WORD;
    if (!illegal_nxt) begin
      case (i_csr_addr)
        htd_pkg::CSR_TRIGGER_SELECT:      rd_nxt = sel_r;
        htd_pkg::CSR_TRIGGER_DATA_FIRST,
        htd_pkg::CSR_TRIGGER_DATA_SECOND,
        htd_pkg::CSR_TRIGGER_DATA_THIRD:  rd_nxt = tif.rdata;          // RL6 RL7 RL8
        htd_pkg::CSR_DEBUG_CONTROL:       rd_nxt = dcsr_r;
        htd_pkg::CSR_DEBUG_PC:            rd_nxt = dpc_r;
        htd_pkg::CSR_DEBUG_SCRATCH:       rd_nxt = scratch_r;
        default:                          rd_nxt = htd_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_csr_ack     <= 1'b0;
      o_csr_illegal <= 1'b0;
      o_csr_rdata   <= htd_pkg::ZERO_WORD;
    end else begin
      o_csr_ack     <= i_csr_valid;
      o_csr_illegal <= illegal_nxt;
      o_csr_rdata   <= rd_nxt;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_sel_legal: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL4
    sel_r < 32'(NUM_TRIG))
    else $error("selection index names unimplemented trigger");
  a_dbg_only_m: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL1
    i_csr_valid && !i_debug_mode && is_debug_only(i_csr_addr) |=> o_csr_illegal && o_csr_ack)
    else $error("debug-only CSR accessed from machine mode without trap");
  a_trig_m_ok: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL1
    i_csr_valid && i_csr_addr == htd_pkg::CSR_TRIGGER_SELECT |=> !o_csr_illegal)
    else $error("selection register access trapped");
  a_dmode_trap: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL10
    i_csr_valid && !i_debug_mode && tif.dmode && is_trig_data(i_csr_addr) |=> o_csr_illegal)
    else $error("machine access to debug-view trigger not trapped");
  a_dpc_capture: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL11
    i_debug_enter |=> dpc_r == $past(i_pc))
    else $error("debug PC not captured on entry");
  a_resume_pc: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL12
    i_debug_exit |=> o_resume && o_resume_pc == $past(dpc_r))
    else $error("resume not at debug PC");
  a_resume_pulse: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL12
    !i_debug_exit |=> !o_resume)
    else $error("resume pulse without exit");
  a_type_read: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL7
    i_csr_valid && !i_csr_write && !illegal_nxt && i_csr_addr == htd_pkg::CSR_TRIGGER_DATA_FIRST
    |=> o_csr_rdata[htd_pkg::TYPE_MSB:htd_pkg::TYPE_LSB] == htd_pkg::TYPE_MATCH)
    else $error("first trigger data type code wrong");
  a_sel_write: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL3
    ok && i_csr_addr == htd_pkg::CSR_TRIGGER_SELECT && i_csr_wdata < 32'(NUM_TRIG)
    |=> sel_r == $past(i_csr_wdata))
    else $error("legal index write not kept");
  a_unmapped: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL16
    i_csr_valid && !is_trig_data(i_csr_addr) && !is_debug_only(i_csr_addr) &&
    i_csr_addr != htd_pkg::CSR_TRIGGER_SELECT |=> o_csr_illegal)
    else $error("unmapped CSR not trapped");
  a_ack_answer: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL16
    i_csr_valid |=> o_csr_ack)
    else $error("access not answered");
  a_trap_zero: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL10
    o_csr_illegal |-> o_csr_rdata == htd_pkg::ZERO_WORD)
    else $error("trapped access returned data");
endmodule
`default_nettype wire

/* logic/htd_pkg.sv */
// Package: CSR addresses, field layout and constants of the debug CSR block
package htd_pkg;
  localparam logic [11:0] CSR_TRIGGER_SELECT = 12'h07A0;
  localparam logic [11:0] CSR_TRIGGER_DATA_FIRST = 12'h07A1;
  localparam logic [11:0] CSR_TRIGGER_DATA_SECOND = 12'h07A2;
  localparam logic [11:0] CSR_TRIGGER_DATA_THIRD = 12'h07A3;
  localparam logic [11:0] CSR_DEBUG_CONTROL = 12'h07B0;
  localparam logic [11:0] CSR_DEBUG_PC = 12'h07B1;
  localparam logic [11:0] CSR_DEBUG_SCRATCH = 12'h07B2;
  localparam int XLEN = 32;
  localparam int TYPE_MSB = 31;
  localparam int TYPE_LSB = 28;
  localparam int DMODE_BIT = 27;
  localparam int MASKMAX_MSB = 26;
  localparam int MASKMAX_LSB = 21;
  localparam int SELECT_BIT = 19;
  localparam int TIMING_BIT = 18;
  localparam int ACTION_MSB = 17;
  localparam int ACTION_LSB = 12;
  localparam logic [3:0] TYPE_NONE = 4'h0;
  localparam logic [3:0] TYPE_MATCH = 4'h2;
  localparam logic [5:0] MASKMAX_VAL = 6'h04;
  localparam logic [5:0] ACTION_MAX = 6'h01;
  localparam int NUM_TRIGGERS = 8;
  localparam logic [31:0] DEBUG_CONTROL_RST = 32'h4000_0003;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {HTD_OP_NONE, HTD_OP_READ, HTD_OP_WRITE} htd_op_t;
endpackage

/* logic/htd_trig_if.sv */
// Interface: access path between the CSR decoder and the trigger bank
`timescale 1ns/1ps
`default_nettype none
interface htd_trig_if #(parameter int IDX_W = 3);
  logic [IDX_W-1:0] sel;
  logic [1:0]       field;
  logic             wr;
  logic             dbg;
  logic [31:0]      wdata;
  logic [31:0]      rdata;
  logic             dmode;
  modport ctl  (output sel, field, wr, dbg, wdata, input rdata, dmode);
  modport bank (input sel, field, wr, dbg, wdata, output rdata, dmode);
endinterface
`default_nettype wire

/* logic/htd_trig_bank.sv */
// Module: bank of trigger registers reached through the selection index
`timescale 1ns/1ps
`default_nettype none
module htd_trig_bank #(
  parameter int NUM = htd_pkg::NUM_TRIGGERS,
  parameter int IDX_W = 3
) (
  input  wire logic i_core_clk,  // Core clock
  input  wire logic i_srst,      // Synchronous reset
  htd_trig_if.bank  t            // Access path
);
  logic [31:0] ctl_r  [NUM];
  logic [31:0] addr_r [NUM];
  logic [31:0] aux_r  [NUM];
  logic [31:0] cur;

  if (NUM < 1 || NUM > (1 << IDX_W)) begin : g_bad_num
    $error("NUM out of range");
  end

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Debug-view bit may only be changed from debug mode
  function automatic logic [31:0] legal_ctl(input logic [31:0] w, input logic [31:0] old, input logic dbg);
    logic [31:0] v;
    v = w;
    v[htd_pkg::TYPE_MSB:htd_pkg::TYPE_LSB] = htd_pkg::TYPE_MATCH;       // RL7 RL14
    v[htd_pkg::MASKMAX_MSB:htd_pkg::MASKMAX_LSB] = htd_pkg::MASKMAX_VAL;
    v[htd_pkg::SELECT_BIT] = 1'b0;
    v[htd_pkg::TIMING_BIT] = 1'b0;
    if (w[htd_pkg::ACTION_MSB:htd_pkg::ACTION_LSB] > htd_pkg::ACTION_MAX)
      v[htd_pkg::ACTION_MSB:htd_pkg::ACTION_LSB] = old[htd_pkg::ACTION_MSB:htd_pkg::ACTION_LSB];
    if (!dbg)
      v[htd_pkg::DMODE_BIT] = old[htd_pkg::DMODE_BIT];                 // RL9
    return v;
  endfunction

  generate
    for (genvar g = 0; g < NUM; g++) begin : g_trig                    // RL15
      always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
          ctl_r[g]  <= {htd_pkg::TYPE_MATCH, 1'b0, htd_pkg::MASKMAX_VAL, 21'h00_0000};
          addr_r[g] <= htd_pkg::ZERO_WORD;
          aux_r[g]  <= htd_pkg::ZERO_WORD;
        end else if (t.wr && t.sel == IDX_W'(g)) begin                 // RL2 RL6
          if (t.field == 2'd0)
            ctl_r[g] <= legal_ctl(t.wdata, ctl_r[g], t.dbg);
          else if (t.field == 2'd1)
            addr_r[g] <= t.wdata;
          else if (t.field == 2'd2)
            aux_r[g] <= t.wdata;                                       // RL6
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    cur = htd_pkg::ZERO_WORD;
    case (t.field)
      2'd0:    cur = ctl_r[t.sel];
      2'd1:    cur = addr_r[t.sel];
      2'd2:    cur = aux_r[t.sel];                                    // RL6
      default: cur = htd_pkg::ZERO_WORD;                              // Unused field code reads zero
    endcase
  end
  assign t.rdata = cur;
  assign t.dmode = ctl_r[t.sel][htd_pkg::DMODE_BIT];

  a_type_fixed: assert property (@(posedge i_core_clk) disable iff (i_srst)  // RL14
    ctl_r[t.sel][htd_pkg::TYPE_MSB:htd_pkg::TYPE_LSB] == htd_pkg::TYPE_MATCH)
    else $error("trigger type code not 2");
endmodule
`default_nettype wire

/* bench/htd_core_model.sv */
// Model of the core that issues CSR accesses and debug mode events
`timescale 1ns/1ps
`default_nettype none
module htd_core_model (
  input  wire logic        i_core_clk,    // Core clock
  input  wire logic        i_csr_ack,     // Access answered
  input  wire logic [31:0] i_csr_rdata,   // Read data
  input  wire logic        i_csr_illegal, // Exception flag
  output logic             o_csr_valid,   // Access request
  output logic             o_csr_write,   // 1 write, 0 read
  output logic [11:0]      o_csr_addr,    // CSR address
  output logic [31:0]      o_csr_wdata,   // Write data
  output logic             o_debug_mode,  // Core in debug mode
  output logic             o_debug_enter, // Debug entry pulse
  output logic             o_debug_exit,  // Debug exit pulse
  output logic [31:0]      o_pc           // Program counter
);
  initial begin
    o_csr_valid = 1'b0;
    o_csr_write = 1'b0;
    o_csr_addr = 12'h0000;
    o_csr_wdata = 32'h0000_0000;
    o_debug_mode = 1'b0;
    o_debug_enter = 1'b0;
    o_debug_exit = 1'b0;
    o_pc = 32'h0000_0000;
  end

  // One-cycle request, then a bounded wait for the answer
  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic ill, output logic ok);
    int n;
    @(posedge i_core_clk);
    #1;
    o_csr_valid = 1'b1;
    o_csr_write = wr;
    o_csr_addr = a;
    o_csr_wdata = wd;
    @(posedge i_core_clk);
    #1;
    o_csr_valid = 1'b0;
    // Released address and data lines never keep the stale request; the write line keeps its value
    o_csr_addr = ~a;
    o_csr_wdata = ~wd;
    n = 0;
    while (i_csr_ack !== 1'b1 && n < 4) begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    ok = (i_csr_ack === 1'b1);
    rd = i_csr_rdata;
    ill = i_csr_illegal;
  endtask

  // Presence is learned from the type code, not from the index
  task automatic probe(input logic [31:0] idx, output logic [3:0] kind);
    logic [31:0] d;
    logic        i;
    logic        k;
    access(1'b1, htd_pkg::CSR_TRIGGER_SELECT, idx, d, i, k);
    access(1'b0, htd_pkg::CSR_TRIGGER_DATA_FIRST, 32'h0000_0000, d, i, k);
    kind = d[31:28];
  endtask

  task automatic enter(input logic [31:0] p);
    @(posedge i_core_clk);
    #1;
    o_pc = p;
    o_debug_enter = 1'b1;
    o_debug_mode = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_debug_enter = 1'b0;
  endtask

  task automatic leave();
    @(posedge i_core_clk);
    #1;
    o_debug_exit = 1'b1;
    @(posedge i_core_clk);
    #1;
    o_debug_exit = 1'b0;
    o_debug_mode = 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/hart_trigger_debug_csrs_test.sv */
// Testbench: CSR access, banking, privilege and debug PC checks
`timescale 1ns/1ps
`default_nettype none
module hart_trigger_debug_csrs_test;
  localparam logic [11:0] SEL = htd_pkg::CSR_TRIGGER_SELECT;
  localparam logic [11:0] D1  = htd_pkg::CSR_TRIGGER_DATA_FIRST;
  localparam logic [11:0] D2  = htd_pkg::CSR_TRIGGER_DATA_SECOND;
  localparam logic [11:0] D3  = htd_pkg::CSR_TRIGGER_DATA_THIRD;
  localparam logic [11:0] DPC = htd_pkg::CSR_DEBUG_PC;
  logic        clk;
  logic        srst;
  logic        valid, wr, dm, ent, ext, ack, ill, res;
  logic [11:0] addr;
  logic [31:0] wdata, pc, rdata, res_pc;
  logic [3:0]  kind;
  int          errors, tests_run, cycles;

  htd_core_model core (.i_core_clk(clk), .i_csr_ack(ack), .i_csr_rdata(rdata), .i_csr_illegal(ill),
    .o_csr_valid(valid), .o_csr_write(wr), .o_csr_addr(addr), .o_csr_wdata(wdata),
    .o_debug_mode(dm), .o_debug_enter(ent), .o_debug_exit(ext), .o_pc(pc));

  htd_debug_csrs dut (.i_core_clk(clk), .i_srst(srst), .i_csr_valid(valid), .i_csr_write(wr),
    .i_csr_addr(addr), .i_csr_wdata(wdata), .i_debug_mode(dm), .i_debug_enter(ent),
    .i_debug_exit(ext), .i_pc(pc), .o_csr_ack(ack), .o_csr_rdata(rdata),
    .o_csr_illegal(ill), .o_resume(res), .o_resume_pc(res_pc));

  initial begin
    clk = 1'b0;
  end
  always #10 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_ill);
    logic [31:0] d;
    logic        i;
    logic        k;
    core.access(1'b0, a, 32'h0000_0000, d, i, k);
    check_bit(k, 1'b1);
    check_bit(i, exp_ill);
    check_word(d, exp);
  endtask

  task automatic wr_do(input logic [11:0] a, input logic [31:0] w, input logic exp_ill);
    logic [31:0] d;
    logic        i;
    logic        k;
    core.access(1'b1, a, w, d, i, k);
    check_bit(k, 1'b1);
    check_bit(i, exp_ill);
  endtask

  initial begin
    srst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    rd_chk(SEL, 32'h0000_0000, 1'b0);
    rd_chk(D1, 32'h2080_0000, 1'b0);
    for (int a = 0; a < 3; a++) begin
      rd_chk(htd_pkg::CSR_DEBUG_CONTROL + 12'(a), 32'h0000_0000, 1'b1);
    end
    rd_chk(12'h07A4, 32'h0000_0000, 1'b1);
    // Fill every bank, then read each one back through the index
    for (int i = 0; i < 8; i++) begin
      wr_do(SEL, 32'(i), 1'b0);
      wr_do(D2, 32'h1000_0000 + 32'(i), 1'b0);
    end
    for (int i = 0; i < 8; i++) begin
      core.probe(32'(i), kind);
      check_word({28'h000_0000, kind}, 32'h0000_0002);
      rd_chk(D2, 32'h1000_0000 + 32'(i), 1'b0);
    end
    wr_do(SEL, 32'h0000_0005, 1'b0);
    wr_do(SEL, 32'h0000_0008, 1'b0);
    wr_do(SEL, 32'hFFFF_FFFF, 1'b0);
    rd_chk(SEL, 32'h0000_0005, 1'b0);
    wr_do(D1, 32'h0000_1000, 1'b0);
    wr_do(D1, 32'hFFFF_FFFF, 1'b0);
    rd_chk(D1, 32'h2090_1FFF, 1'b0);
    core.enter(32'h8000_1234);
    rd_chk(DPC, 32'h8000_1234, 1'b0);
    rd_chk(htd_pkg::CSR_DEBUG_CONTROL, 32'h4000_0003, 1'b0);
    wr_do(htd_pkg::CSR_DEBUG_SCRATCH, 32'h5A5A_0001, 1'b0);
    rd_chk(htd_pkg::CSR_DEBUG_SCRATCH, 32'h5A5A_0001, 1'b0);
    wr_do(SEL, 32'h0000_0003, 1'b0);
    wr_do(D1, 32'h0800_0000, 1'b0);
    rd_chk(D1, 32'h2880_0000, 1'b0);
    wr_do(DPC, 32'h8000_2000, 1'b0);
    core.leave();
    check_bit(res, 1'b1);
    check_word(res_pc, 32'h8000_2000);
    @(posedge clk);
    #1;
    check_bit(res, 1'b0);
    check_word(res_pc, 32'h8000_2000);
    rd_chk(D1, 32'h0000_0000, 1'b1);
    wr_do(D2, 32'hDEAD_0000, 1'b1);
    rd_chk(SEL, 32'h0000_0003, 1'b0);
    core.enter(32'h0000_0040);
    rd_chk(D2, 32'h1000_0003, 1'b0);
    wr_do(D3, 32'h1234_5678, 1'b0);
    rd_chk(D3, 32'h1234_5678, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
